/* File: srdc_top.sv */
// Purpose: sysref-based automatic sampling-clock delay calibration
// Assumes: register port and manual delay are on clk; sysref is a pin
// Notes: Function
`default_nettype none
module srdc_top #(
    parameter int unsigned BOUND_SCALE = srdc_pkg::BOUND_SCALE
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    // sysref and manual delay
    input wire logic sysref_in,
    input wire logic [16:0] manual_delay,
    // results
    output logic [16:0] delay_setting_q,
    output logic cal_done_flag_q,
    output logic cal_fail_q,
    output logic [16:0] cal_delay_result_q
);
    srdc_pkg::srdc_state_t state_q;
    logic [7:0] sysref_cal_enable_q;
    logic [7:0] sysref_cal_config_q;
    logic enable_prev_q;
    logic start;
    logic sr_level;
    logic sr_rise;
    logic [15:0] since_rise;
    logic [8:0] win_cnt_q;
    logic [8:0] avg_cnt_q;
    logic [15:0] wait_cnt_q;
    logic [16:0] sum_q;
    logic [31:0] dur_cnt_q;
    logic [1:0] cal_average_select;
    logic [1:0] accumulation_length_select;
    logic [8:0] avg_high;

    function automatic logic [8:0] pow4(input logic [1:0] code);
        pow4 = 9'h004 << {code, 1'b0};
    endfunction

    function automatic logic [15:0] max_period(input logic [1:0] code);
        case (code)
            2'h0: max_period = srdc_pkg::MAX_PERIOD_0;
            2'h1: max_period = srdc_pkg::MAX_PERIOD_1;
            2'h2: max_period = srdc_pkg::MAX_PERIOD_2;
            default: max_period = srdc_pkg::MAX_PERIOD_3;
        endcase
    endfunction

    assign cal_average_select = sysref_cal_config_q[srdc_pkg::AVG_LSB +: 2];
    assign accumulation_length_select = sysref_cal_config_q[srdc_pkg::ACCUM_LSB +: 2];
    assign start = sysref_cal_enable_q[srdc_pkg::ENABLE_BIT] & ~enable_prev_q;
    assign avg_high = 9'(sum_q >> {cal_average_select, 1'b1} >> 1);

    srdc_edge_meter u_meter (
        .clk(clk),
        .reset_n(reset_n),
        .sysref_in(sysref_in),
        .sysref_level_q(sr_level),
        .sysref_rise_q(sr_rise),
        .since_rise_q(since_rise)
    );

    // ==========================================================
    // register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sysref_cal_enable_q <= srdc_pkg::ENABLE_RESET;
            sysref_cal_config_q <= srdc_pkg::CONFIG_RESET;
            enable_prev_q <= 1'b0;
        end else begin
            enable_prev_q <= sysref_cal_enable_q[srdc_pkg::ENABLE_BIT];
            if (reg_wr_en && reg_addr == srdc_pkg::ADDR_ENABLE) begin
                sysref_cal_enable_q <= reg_wdata;
            end
            if (reg_wr_en && reg_addr == srdc_pkg::ADDR_CONFIG) begin
                sysref_cal_config_q <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // register reads, one cycle latency
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            case (reg_addr)
                srdc_pkg::ADDR_ENABLE: reg_rdata_q <= sysref_cal_enable_q;
                srdc_pkg::ADDR_CONFIG: reg_rdata_q <= sysref_cal_config_q;
                srdc_pkg::ADDR_STAT0: reg_rdata_q <= cal_delay_result_q[7:0];
                srdc_pkg::ADDR_STAT1: reg_rdata_q <= cal_delay_result_q[15:8];
                srdc_pkg::ADDR_STAT2: reg_rdata_q <= {6'h00, cal_done_flag_q, cal_delay_result_q[16]};
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // calibration sequence
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= srdc_pkg::ST_IDLE;
            win_cnt_q <= 9'h000;
            avg_cnt_q <= 9'h000;
            wait_cnt_q <= 16'h0000;
            sum_q <= 17'h00000;
            cal_delay_result_q <= 17'h00000;
        end else if (!sysref_cal_enable_q[srdc_pkg::ENABLE_BIT]) begin
            state_q <= srdc_pkg::ST_IDLE;
        end else if (start) begin
            state_q <= srdc_pkg::ST_WAIT_EDGE;
            wait_cnt_q <= 16'h0000;
            win_cnt_q <= 9'h000;
            avg_cnt_q <= 9'h000;
            sum_q <= 17'h00000;
        end else begin
            case (state_q)
                srdc_pkg::ST_WAIT_EDGE: begin
                    wait_cnt_q <= wait_cnt_q + 16'h0001;
                    if (sr_rise) begin
                        state_q <= srdc_pkg::ST_ACCUM;
                    end else if (wait_cnt_q > max_period(accumulation_length_select)) begin
                        state_q <= srdc_pkg::ST_FAIL;
                    end
                end
                srdc_pkg::ST_ACCUM: begin
                    if (since_rise > max_period(accumulation_length_select)) begin
                        state_q <= srdc_pkg::ST_FAIL;
                    end else begin
                        sum_q <= sum_q + {16'h0000, sr_level};
                        if (win_cnt_q == pow4(accumulation_length_select) - 9'h001) begin
                            win_cnt_q <= 9'h000;
                            avg_cnt_q <= avg_cnt_q + 9'h001;
                            if (avg_cnt_q == pow4(cal_average_select) - 9'h001) begin
                                state_q <= srdc_pkg::ST_DONE;
                            end
                        end else begin
                            win_cnt_q <= win_cnt_q + 9'h001;
                        end
                    end
                end
                srdc_pkg::ST_DONE: begin
                    // invert, coarse, fine; latched once so the applied delay stays put
                    if (!cal_done_flag_q) begin
                        cal_delay_result_q <= {avg_high[8], since_rise[7:0], avg_high[7:0]};
                    end
                end
                srdc_pkg::ST_FAIL: state_q <= srdc_pkg::ST_FAIL;
                default: state_q <= srdc_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // duration count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dur_cnt_q <= 32'h00000000;
        end else if (start || state_q == srdc_pkg::ST_IDLE) begin
            dur_cnt_q <= 32'h00000000;
        end else if (state_q == srdc_pkg::ST_WAIT_EDGE || state_q == srdc_pkg::ST_ACCUM) begin
            dur_cnt_q <= dur_cnt_q + 32'h00000001;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_done_flag_q <= 1'b0;
            cal_fail_q <= 1'b0;
            delay_setting_q <= 17'h00000;
        end else begin
            cal_done_flag_q <= sysref_cal_enable_q[srdc_pkg::ENABLE_BIT] && !start
                && state_q == srdc_pkg::ST_DONE;
            cal_fail_q <= sysref_cal_enable_q[srdc_pkg::ENABLE_BIT] && !start
                && state_q == srdc_pkg::ST_FAIL;
            if (sysref_cal_enable_q[srdc_pkg::ENABLE_BIT]) begin
                delay_setting_q <= cal_delay_result_q;
            end else begin
                delay_setting_q <= manual_delay;
            end
        end
    end

    // ==========================================================
    // assertions
    manual_path_a: assert property (@(posedge clk) disable iff (!reset_n)
        !sysref_cal_enable_q[0] |=> delay_setting_q == $past(manual_delay))
        else $error("manual delay not applied while disabled");
    auto_path_a: assert property (@(posedge clk) disable iff (!reset_n)
        sysref_cal_enable_q[0] |=> delay_setting_q == $past(cal_delay_result_q))
        else $error("calibrated delay not applied while enabled");
    start_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
        start |=> state_q == srdc_pkg::ST_WAIT_EDGE)
        else $error("enable rise did not start sequence");
    no_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == srdc_pkg::ST_DONE && $stable(sysref_cal_enable_q[0]) && !start
        |=> state_q == srdc_pkg::ST_DONE)
        else $error("sequence restarted without enable rise");
    window_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        win_cnt_q <= pow4(accumulation_length_select) - 9'h001 || state_q != srdc_pkg::ST_ACCUM)
        else $error("accumulation window overran");
    avg_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == srdc_pkg::ST_ACCUM |-> avg_cnt_q < pow4(cal_average_select))
        else $error("average count overran");
    period_fail_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == srdc_pkg::ST_ACCUM && !start && sysref_cal_enable_q[0]
        && since_rise > max_period(accumulation_length_select) |=> state_q == srdc_pkg::ST_FAIL)
        else $error("long sysref period did not fail");
    duration_a: assert property (@(posedge clk) disable iff (!reset_n)
        dur_cnt_q <= BOUND_SCALE * (32'h1 << {4'(cal_average_select) + 4'(accumulation_length_select) + 4'h2, 1'b0}))
        else $error("calibration exceeded duration bound");
    done_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        cal_done_flag_q |-> $past(sysref_cal_enable_q[0]) && $past(state_q) == srdc_pkg::ST_DONE)
        else $error("done without enable and completion");
    done_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        start |=> !cal_done_flag_q ##1 !cal_done_flag_q)
        else $error("done not cleared at new start");
    result_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        cal_done_flag_q |=> !cal_done_flag_q || $stable(cal_delay_result_q))
        else $error("result changed while done");
    cover_done_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(cal_done_flag_q));
    cover_fail_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(cal_fail_q));
    cover_restart_c: cover property (@(posedge clk) disable iff (!reset_n)
        cal_done_flag_q ##1 !sysref_cal_enable_q[0] ##[1:20] start);
endmodule
`default_nettype wire

/* File: srdc_pkg.sv */
// Purpose: shared constants for the sysref delay calibration block
// Assumes: 8-bit register port, 12-bit register address
// Notes: field positions and reset values of the two control registers
`default_nettype none
package srdc_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] ADDR_ENABLE = 12'h2B0;
    localparam logic [11:0] ADDR_CONFIG = 12'h2B1;
    localparam logic [11:0] ADDR_STAT0 = 12'h2B2;
    localparam logic [11:0] ADDR_STAT1 = 12'h2B3;
    localparam logic [11:0] ADDR_STAT2 = 12'h2B4;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h05;
    localparam int ENABLE_BIT = 0;
    localparam int AVG_LSB = 2;
    localparam int ACCUM_LSB = 0;
    localparam int DONE_BIT = 1;
    // ==========================================================
    // sequence limits
    localparam logic [15:0] MAX_PERIOD_0 = 16'h0080;
    localparam logic [15:0] MAX_PERIOD_1 = 16'h0680;
    localparam logic [15:0] MAX_PERIOD_2 = 16'h1E80;
    localparam logic [15:0] MAX_PERIOD_3 = 16'h7E80;
    localparam int BOUND_SCALE = 384 * 19;
    // ==========================================================
    // sequence states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_EDGE = 3'b001,
        ST_ACCUM = 3'b010,
        ST_DONE = 3'b011,
        ST_FAIL = 3'b100
    } srdc_state_t;
endpackage
`default_nettype wire

/* File: srdc_edge_meter.sv */
// Purpose: synchronise the sysref pin and time its rising edges
// Assumes: sysref is asynchronous to clk
// Notes: since_rise saturates at all ones
`default_nettype none
module srdc_edge_meter (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // sysref pin
    input wire logic sysref_in,
    // measurements
    output logic sysref_level_q,
    output logic sysref_rise_q,
    output logic [15:0] since_rise_q
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // ==========================================================
    // two-stage synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= sysref_in;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // edge detect and cycle count since last rise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
            sysref_level_q <= 1'b0;
            sysref_rise_q <= 1'b0;
            since_rise_q <= 16'hFFFF;
        end else begin
            prev_q <= sync2_q;
            sysref_level_q <= sync2_q;
            sysref_rise_q <= sync2_q & ~prev_q;
            if (sync2_q & ~prev_q) begin
                since_rise_q <= 16'h0000;
            end else if (since_rise_q != 16'hFFFF) begin
                since_rise_q <= since_rise_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: srdc_sysref_src.sv */
// Purpose: periodic sysref source for the calibration bench
// Assumes: period in clk cycles, high for half of it
// Notes: edges land 37 ns after clk so they are not aligned to it
`default_nettype none
module srdc_sysref_src (
    // clock
    input wire logic clk,
    // control
    input wire logic run,
    input wire logic [15:0] period,
    // sysref pin
    output logic sysref_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial begin
        sysref_out = 1'b0;
    end
    // ==========================================================
    // pulse train, held low while stopped
    always @(posedge clk) begin
        if (!run) begin
            cnt <= 0;
            sysref_out <= #37 1'b0;
        end else begin
            cnt <= (cnt + 1 >= int'(period)) ? 0 : cnt + 1;
            sysref_out <= #37 (cnt < int'(period) / 2);
        end
    end
endmodule
`default_nettype wire

/* File: srdc_top_tb.sv */
// Purpose: self-checking bench for the sysref delay calibration block
// Assumes: 10 MHz clock, inputs driven 10 ns after the rising edge
// Notes: short sysref periods keep the run brief
`default_nettype none
module srdc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata_q;
    logic sysref_in;
    logic [16:0] manual_delay = 17'h1ABCD;
    logic [16:0] delay_setting_q;
    logic cal_done_flag_q;
    logic cal_fail_q;
    logic [16:0] cal_delay_result_q;
    logic src_run = 1'b0;
    logic [15:0] src_period = 16'h0040;
    int failures = 0;
    int n_tests = 0;
    int cycles;
    always #50 clk = ~clk;
    // ==========================================================
    // design and sysref source
    srdc_top i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .sysref_in(sysref_in),
        .manual_delay(manual_delay), .delay_setting_q(delay_setting_q),
        .cal_done_flag_q(cal_done_flag_q), .cal_fail_q(cal_fail_q),
        .cal_delay_result_q(cal_delay_result_q));
    srdc_sysref_src i_src (.clk(clk), .run(src_run), .period(src_period), .sysref_out(sysref_in));
    // ==========================================================
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #10;
    endtask
    task automatic reg_wr(input logic [11:0] addr, input logic [7:0] data);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr_en = 1'b1;
        tick();
        reg_wr_en = 1'b0;
        tick();
    endtask
    task automatic reg_rd(input logic [11:0] addr, input logic [7:0] exp, input string name);
        reg_addr = addr;
        tick();
        check(name, reg_rdata_q, exp);
    endtask
    // program, enable and wait for done or fail
    task automatic run_cal(input logic [7:0] cfg, input logic [15:0] period, input logic exp_done);
        int bound;
        int shortest;
        logic [16:0] res;
        bound = 384 * 19 * (4 ** (int'(cfg[3:2]) + int'(cfg[1:0]) + 2));
        shortest = (4 ** (int'(cfg[3:2]) + 1)) * (4 ** (int'(cfg[1:0]) + 1));
        src_period = period;
        src_run = 1'b1;
        reg_wr(12'h2B0, 8'h00);
        reg_wr(12'h2B1, cfg);
        reg_rd(12'h2B1, cfg, "config readback");
        reg_wr(12'h2B0, 8'h01); // no converter calibration runs here
        tick();
        cycles = 1;
        check("done at start", cal_done_flag_q, 1'b0);
        while (!(cal_done_flag_q === 1'b1 || cal_fail_q === 1'b1) && cycles < 10000) begin
            tick();
            cycles++;
        end
        if (cycles >= 10000) begin
            failures++;
            test_done();
        end
        check("done", cal_done_flag_q, exp_done);
        check("fail", cal_fail_q, !exp_done);
        check("within bound", cycles <= bound, 1'b1);
        if (exp_done) begin
            check("averaged length", cycles >= shortest, 1'b1);
            res = cal_delay_result_q;
            tick();
            check("result held", cal_delay_result_q, res);
            check("applied delay", delay_setting_q, res);
            reg_rd(12'h2B2, res[7:0], "status fine");
            reg_rd(12'h2B3, res[15:8], "status coarse");
            reg_rd(12'h2B4, {6'h00, 1'b1, res[16]}, "status done");
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        #10;
        reset_n = 1'b1;
        tick();
        reg_rd(12'h2B0, 8'h00, "enable reset");
        reg_rd(12'h2B1, 8'h05, "config reset");
        reg_wr(12'h2A0, 8'hFF);
        reg_rd(12'h2A0, 8'h00, "unmapped");
        check("manual delay", delay_setting_q, manual_delay);
        manual_delay = 17'h00F0F;
        tick();
        tick();
        check("manual follows", delay_setting_q, manual_delay);
        check("done idle", cal_done_flag_q, 1'b0);
        for (int i = 0; i < 4; i++) begin
            run_cal({4'h0, i[1:0], 2'b00}, 16'h0064, 1'b1);
            run_cal({4'h0, 2'b00, i[1:0]}, 16'h0064, 1'b1);
        end
        manual_delay = 17'h15555;
        reg_wr(12'h2B0, 8'h01);
        tick();
        check("no restart", cal_done_flag_q, 1'b1);
        check("manual ignored", delay_setting_q, cal_delay_result_q);
        reg_wr(12'h2B0, 8'h00);
        tick();
        check("done cleared", cal_done_flag_q, 1'b0);
        check("manual back", delay_setting_q, manual_delay);
        run_cal(8'h0D, 16'd1600, 1'b1);
        run_cal(8'h0D, 16'd1700, 1'b0);
        run_cal(8'h0C, 16'd200, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
